// *** common/pil_params.svh ***
// Constants for the processor identification logic
`ifndef PIL_PARAMS_SVH
`define PIL_PARAMS_SVH

// ==========================================================
// Register word offsets on the bus
`define PIL_REG_ACC        3'h0
`define PIL_REG_BASE       3'h1
`define PIL_REG_COUNT      3'h2
`define PIL_REG_DATA       3'h3
`define PIL_REG_FLAGS      3'h4
`define PIL_REG_MODE       3'h5
`define PIL_REG_CMD        3'h6

// ==========================================================
// Command and status bits
`define PIL_CMD_GO         0
`define PIL_CMD_DONE       1

// ==========================================================
// Mode register fields and reset
`define PIL_MODE_PE        0
`define PIL_MODE_CPL_LO    1
`define PIL_MODE_CPL_HI    2
`define PIL_MODE_TASK_LO   4
`define PIL_MODE_TASK_HI   7
`define PIL_MODE_RST       8'h00
`define PIL_CPL_KERNEL     2'h0

// ==========================================================
// Flags register bit positions
`define PIL_FLG_IO_PRIVILEGE_FIELD_LO    12
`define PIL_FLG_IO_PRIVILEGE_FIELD_HI    13
`define PIL_FLG_NT         14
`define PIL_FLG_RSV        15
`define PIL_FLG_AC         18
`define PIL_FLG_ID         21

// ==========================================================
// Per-task flag entry layout
`define PIL_FM_IO_PRIVILEGE_FIELD_LO     0
`define PIL_FM_IO_PRIVILEGE_FIELD_HI     1
`define PIL_FM_NT          2
`define PIL_FM_AC          3
`define PIL_FM_ID          4
`define PIL_FM_WIDTH       5
`define PIL_TASK_BITS      4
`define PIL_FM_RST         5'h00

// ==========================================================
// Leaf selection
`define PIL_MAX_LEAF       32'h0000_0002
`define PIL_OVER_IDX       2'h2
`define PIL_WORD_RST       32'h0000_0000

// ==========================================================
// Identity of this core; all values arbitrary
`define PIL_VENDOR_B       32'h5a5a_0001
`define PIL_VENDOR_C       32'h5a5a_0002
`define PIL_VENDOR_D       32'h5a5a_0003
`define PIL_TYPE           2'h0
`define PIL_FAMILY         4'h1
`define PIL_MODEL          4'h2
`define PIL_STEPPING       4'h3
`define PIL_CACHE_A        32'h0000_0001
`define PIL_CACHE_B        32'h0000_0000
`define PIL_CACHE_C        32'h0000_0000
`define PIL_CACHE_D        32'h0000_0004
// Feature word: fpu, v86, dbg, pse, tsc, msr, pae, mce, cx8,
// on_chip_interrupt_controller, mtrr, pge, mca, cmov in bits 0..9,12..15
`define PIL_FEATURES       32'h0000_f3ff

`endif

// *** common/pil_pkg.sv ***
// Types shared by the processor identification logic
`include "pil_params.svh"
package pil_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WORK = 3'b010,
        ST_ACK  = 3'b100
    } pil_state_type;
    typedef logic [`PIL_FM_WIDTH-1:0]  pil_fm_type;
    typedef logic [`PIL_TASK_BITS-1:0] pil_task_type;
endpackage

// *** rtl/pil_flag_mem.sv ***
// Per-task flag store with registered read data
`timescale 1ns/100ps
`default_nettype none
module pil_flag_mem
    import pil_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         wr_en,
    input  wire pil_task_type wr_addr,
    input  wire pil_fm_type   wr_data,
    input  wire pil_task_type rd_addr,
    output var  pil_fm_type   rd_data
);
    // ======================================================
    // Storage, one entry per task
    pil_fm_type mem_ff [0:(1<<`PIL_TASK_BITS)-1];

    // Write port and registered read port
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
        rd_data <= mem_ff[rd_addr];
    end
endmodule
`default_nettype wire

// *** rtl/pil_leaf_rom.sv ***
// Identification leaf table with registered outputs
`timescale 1ns/100ps
`default_nettype none
module pil_leaf_rom
    import pil_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [1:0]  leaf,
    output logic      [31:0] res_acc,
    output logic      [31:0] res_base,
    output logic      [31:0] res_count,
    output logic      [31:0] res_data
);
    // ======================================================
    // Leaf 1 signature word of this core
    logic [31:0] sig;
    assign sig = {18'h00000, `PIL_TYPE, `PIL_FAMILY, `PIL_MODEL, `PIL_STEPPING};

    // Table lookup, one cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            res_acc   <= `PIL_WORD_RST;
            res_base  <= `PIL_WORD_RST;
            res_count <= `PIL_WORD_RST;
            res_data  <= `PIL_WORD_RST;
        end else begin
            case (leaf)
                2'h0: begin
                    res_acc   <= `PIL_MAX_LEAF;
                    res_base  <= `PIL_VENDOR_B;
                    res_count <= `PIL_VENDOR_C;
                    res_data  <= `PIL_VENDOR_D;
                end
                2'h1: begin
                    res_acc   <= sig;
                    res_base  <= `PIL_WORD_RST;
                    res_count <= `PIL_WORD_RST;
                    res_data  <= `PIL_FEATURES;
                end
                default: begin
                    res_acc   <= `PIL_CACHE_A;
                    res_base  <= `PIL_CACHE_B;
                    res_count <= `PIL_CACHE_C;
                    res_data  <= `PIL_CACHE_D;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/pil_ident_top.sv ***
// Processor identification logic with flags probe bits
`timescale 1ns/100ps
`default_nettype none
module pil_ident_top
    import pil_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    // ======================================================
    // State
    pil_state_type state_ff;
    pil_state_type nxt_state;
    logic [31:0]   acc_ff;
    logic [31:0]   base_ff;
    logic [31:0]   count_ff;
    logic [31:0]   data_ff;
    logic [7:0]    mode_ff;
    logic          done_ff;
    logic          nxt_done;
    logic [31:0]   nxt_rdata;

    // ======================================================
    // Bus decode
    logic        in_work;
    logic        wr_now;
    logic        rd_now;
    logic [31:0] wmask;
    logic        hit_acc;
    logic        hit_base;
    logic        hit_count;
    logic        hit_data;
    logic        hit_flags;
    logic        hit_mode;
    logic        hit_cmd;

    // Decode of the held request in the work cycle
    assign in_work   = (state_ff == ST_WORK);
    assign wr_now    = in_work & avs_write;
    assign rd_now    = in_work & avs_read;
    assign wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign hit_acc   = (avs_address == `PIL_REG_ACC);
    assign hit_base  = (avs_address == `PIL_REG_BASE);
    assign hit_count = (avs_address == `PIL_REG_COUNT);
    assign hit_data  = (avs_address == `PIL_REG_DATA);
    assign hit_flags = (avs_address == `PIL_REG_FLAGS);
    assign hit_mode  = (avs_address == `PIL_REG_MODE);
    assign hit_cmd   = (avs_address == `PIL_REG_CMD);

    // ======================================================
    // Mode fields
    logic         prot_mode;
    logic [1:0]   current_privilege_level;
    pil_task_type cur_task;

    // Operating mode, privilege level and running task
    assign prot_mode = mode_ff[`PIL_MODE_PE];
    assign current_privilege_level       = mode_ff[`PIL_MODE_CPL_HI:`PIL_MODE_CPL_LO];
    assign cur_task  = mode_ff[`PIL_MODE_TASK_HI:`PIL_MODE_TASK_LO];

    // ======================================================
    // Identify leaf table
    logic [1:0]  leaf_idx;
    logic [31:0] res_acc;
    logic [31:0] res_base;
    logic [31:0] res_count;
    logic [31:0] res_data;
    logic        do_ident;

    // Leaf index from accumulator, clamp out-of-range selectors
    assign leaf_idx = (acc_ff > `PIL_MAX_LEAF) ? `PIL_OVER_IDX : acc_ff[1:0];
    assign do_ident = wr_now & hit_cmd & avs_byteenable[0]
                    & avs_writedata[`PIL_CMD_GO];

    // Constant table of this core, one cycle to data
    pil_leaf_rom u_rom (
        .core_clk  (core_clk),
        .rst       (rst),
        .leaf      (leaf_idx),
        .res_acc   (res_acc),
        .res_base  (res_base),
        .res_count (res_count),
        .res_data  (res_data)
    );

    // ======================================================
    // Per-task flags
    pil_fm_type  fm_rd;
    pil_fm_type  fm_wd;
    logic        fm_we;
    logic [31:0] flags_view;
    logic [31:0] flags_new;
    logic        io_privilege_field_ok;
    logic [1:0]  io_privilege_field_new;

    // Entry of the running task, held in the small store
    pil_flag_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (fm_we),
        .wr_addr  (cur_task),
        .wr_data  (fm_wd),
        .rd_addr  (cur_task),
        .rd_data  (fm_rd)
    );

    // Flags word as software sees it; bit 15 and others zero
    always_comb begin
        flags_view = `PIL_WORD_RST;
        flags_view[`PIL_FLG_IO_PRIVILEGE_FIELD_HI:`PIL_FLG_IO_PRIVILEGE_FIELD_LO] =
            fm_rd[`PIL_FM_IO_PRIVILEGE_FIELD_HI:`PIL_FM_IO_PRIVILEGE_FIELD_LO];
        flags_view[`PIL_FLG_NT] = fm_rd[`PIL_FM_NT];
        flags_view[`PIL_FLG_AC] = fm_rd[`PIL_FM_AC];
        flags_view[`PIL_FLG_ID] = fm_rd[`PIL_FM_ID];
    end

    // Byte-masked merge of a flags write with the old value
    assign flags_new = (flags_view & ~wmask) | (avs_writedata & wmask);

    // Privilege field writable in real mode or at level 0
    assign io_privilege_field_ok  = ~prot_mode | (current_privilege_level == `PIL_CPL_KERNEL);
    assign io_privilege_field_new = io_privilege_field_ok ? flags_new[`PIL_FLG_IO_PRIVILEGE_FIELD_HI:`PIL_FLG_IO_PRIVILEGE_FIELD_LO]
                              : fm_rd[`PIL_FM_IO_PRIVILEGE_FIELD_HI:`PIL_FM_IO_PRIVILEGE_FIELD_LO];

    // New entry: nested, alignment and identify bits always load
    assign fm_wd = {flags_new[`PIL_FLG_ID],
                    flags_new[`PIL_FLG_AC],
                    flags_new[`PIL_FLG_NT],
                    io_privilege_field_new};
    assign fm_we = wr_now & hit_flags;

    // ======================================================
    // Read data selection
    logic [31:0] status_word;

    // Status shows a finished identify
    always_comb begin
        status_word = `PIL_WORD_RST;
        status_word[`PIL_CMD_DONE] = done_ff;
    end

    // Word for the addressed register, zero when unmapped
    always_comb begin
        nxt_rdata = `PIL_WORD_RST;
        if (rd_now) begin
            case (avs_address)
                `PIL_REG_ACC:   nxt_rdata = acc_ff;
                `PIL_REG_BASE:  nxt_rdata = base_ff;
                `PIL_REG_COUNT: nxt_rdata = count_ff;
                `PIL_REG_DATA:  nxt_rdata = data_ff;
                `PIL_REG_FLAGS: nxt_rdata = flags_view;
                `PIL_REG_MODE:  nxt_rdata = {24'h000000, mode_ff};
                `PIL_REG_CMD:   nxt_rdata = status_word;
                default:        nxt_rdata = `PIL_WORD_RST;
            endcase
        end
    end

    // ======================================================
    // Bus handshake sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (avs_read | avs_write) begin
                    nxt_state = ST_WORK;
                end
            end
            ST_WORK: nxt_state = ST_ACK;
            ST_ACK:  nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Sequencer, wait and read data registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff        <= ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `PIL_WORD_RST;
        end else begin
            state_ff        <= nxt_state;
            avs_waitrequest <= ~in_work;
            avs_readdata    <= nxt_rdata;
        end
    end

    // ======================================================
    // Done flag: a new identify wins over a clear
    assign nxt_done = do_ident | (done_ff & ~(wr_now & hit_cmd
                    & avs_byteenable[0] & avs_writedata[`PIL_CMD_DONE]));

    // Done and mode registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_ff <= 1'b0;
            mode_ff <= `PIL_MODE_RST;
        end else begin
            done_ff <= nxt_done;
            if (wr_now & hit_mode & avs_byteenable[0]) begin
                mode_ff <= avs_writedata[7:0];
            end
        end
    end

    // ======================================================
    // Accumulator: selector in, result out
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_ff <= `PIL_WORD_RST;
        end else if (do_ident) begin
            acc_ff <= res_acc;
        end else if (wr_now & hit_acc) begin
            acc_ff <= (acc_ff & ~wmask) | (avs_writedata & wmask);
        end
    end

    // Base register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            base_ff <= `PIL_WORD_RST;
        end else if (do_ident) begin
            base_ff <= res_base;
        end else if (wr_now & hit_base) begin
            base_ff <= (base_ff & ~wmask) | (avs_writedata & wmask);
        end
    end

    // Count register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_ff <= `PIL_WORD_RST;
        end else if (do_ident) begin
            count_ff <= res_count;
        end else if (wr_now & hit_count) begin
            count_ff <= (count_ff & ~wmask) | (avs_writedata & wmask);
        end
    end

    // Data register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_ff <= `PIL_WORD_RST;
        end else if (do_ident) begin
            data_ff <= res_data;
        end else if (wr_now & hit_data) begin
            data_ff <= (data_ff & ~wmask) | (avs_writedata & wmask);
        end
    end
endmodule
`default_nettype wire

// *** testbench/pil_ident_monitor.sv ***
// Bus-port checker for the processor identification logic
`timescale 1ns/100ps
`default_nettype none
`include "pil_params.svh"
module pil_ident_monitor
    import pil_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    // ==========================================================
    // Helpers
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic req_on = avs_read || avs_write;
    wire logic rd_ok  = avs_read && !avs_waitrequest;
    wire logic flg_rd = rd_ok && (avs_address == `PIL_REG_FLAGS);

    // ==========================================================
    // Access steps
    sequence s_wait2;
        avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_answer;
        $rose(req_on) |-> s_wait2 ##1 s_ack;
    endproperty
    property p_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_cause;
        !avs_waitrequest |-> $past(req_on, 2);
    endproperty
    property p_idle;
        avs_waitrequest |-> avs_readdata == 32'h0;
    endproperty
    property p_reset;
        disable iff (1'b0) rst |=> avs_waitrequest && (avs_readdata == 32'h0);
    endproperty
    property p_b15;
        flg_rd |-> !avs_readdata[`PIL_FLG_RSV];
    endproperty
    property p_mask;
        flg_rd |-> (avs_readdata & ~32'h0024_7000) == 32'h0;
    endproperty
    property p_unmap;
        rd_ok && (avs_address == 3'h7) |-> avs_readdata == 32'h0;
    endproperty

    a_answer: assert property (p_answer)
        else $error("access not answered on the third edge");
    a_pulse: assert property (p_pulse)
        else $error("waitrequest low for more than one cycle");
    a_cause: assert property (p_cause)
        else $error("answer without a request");
    a_idle: assert property (p_idle)
        else $error("read data not zero while waiting");
    a_reset: assert property (p_reset)
        else $error("bus outputs wrong after reset");
    a_b15: assert property (p_b15)
        else $error("flags bit 15 read as one");
    a_mask: assert property (p_mask)
        else $error("flags unused bit read as one");
    a_unmap: assert property (p_unmap)
        else $error("unmapped word read not zero");
endmodule

bind pil_ident_top pil_ident_monitor i_pil_ident_monitor (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** testbench/pil_ident_top_tb_top.sv ***
// Testbench for the processor identification logic
`timescale 1ns/100ps
`default_nettype none
`include "pil_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pil_ident_top_tb_top
    import pil_pkg::*;
;
    logic        core_clk       = 1'b0;
    logic        rst            = 1'b1;
    logic [2:0]  avs_address    = 3'h0;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rd_val;
    logic [31:0] leaves [6]     = '{32'h0, 32'h1, 32'h2, 32'h3, 32'hffff_ffff, 32'h3};
    int          err_count      = 0;
    int          comparisons    = 0;

    // ==========================================================
    // Clock and device
    always #20 core_clk = ~core_clk;

    pil_ident_top i_pil_ident_top (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // ==========================================================
    // Verdict
    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            err_count++;
        rd_val = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        `CHK(rd_val, e)
    endtask

    // Expected result words of each leaf
    function automatic logic [31:0] leaf_word(input logic [31:0] lf, input int i);
        logic [31:0] t [4];
        if (lf == 32'h0)
            t = '{32'h2, `PIL_VENDOR_B, `PIL_VENDOR_C, `PIL_VENDOR_D};
        else if (lf == 32'h1)
            t = '{32'h0000_0123, 32'h0, 32'h0, `PIL_FEATURES};
        else
            t = '{`PIL_CACHE_A, `PIL_CACHE_B, `PIL_CACHE_C, `PIL_CACHE_D};
        return t[i];
    endfunction

    // ==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values and unmapped word
        for (int i = 0; i < 4; i++)
            rd_chk(i[2:0], 32'h0);
        wr(3'h7, 32'hffff_ffff);
        rd_chk(3'h7, 32'h0);
        // Every leaf, oversize selector 3 twice and 32'hffff_ffff once
        foreach (leaves[j]) begin
            wr(`PIL_REG_ACC, leaves[j]);
            wr(`PIL_REG_CMD, 32'h1);
            bus(1'b0, `PIL_REG_CMD, 32'h0, 4'hf);
            `CHK(rd_val[`PIL_CMD_DONE], 1'b1)
            for (int i = 0; i < 4; i++)
                rd_chk(i[2:0], leaf_word(leaves[j], i));
            // Floating-point unit bit only exists in the feature leaf
            if (leaves[j] == 32'h1)
                `CHK(rd_val[0], 1'b1)
            wr(`PIL_REG_CMD, 32'h2);
            bus(1'b0, `PIL_REG_CMD, 32'h0, 4'hf);
            `CHK(rd_val[`PIL_CMD_DONE], 1'b0)
        end
        // Real mode flag bits
        wr(`PIL_REG_MODE, 32'h0);
        wr(`PIL_REG_FLAGS, 32'hffff_ffff);
        rd_chk(`PIL_REG_FLAGS, 32'h0024_7000);
        bus(1'b1, `PIL_REG_FLAGS, 32'h0, 4'h0);
        rd_chk(`PIL_REG_FLAGS, 32'h0024_7000);
        wr(`PIL_REG_FLAGS, 32'h0);
        rd_chk(`PIL_REG_FLAGS, 32'h0);
        wr(`PIL_REG_FLAGS, 32'h0000_5000);
        rd_chk(`PIL_REG_FLAGS, 32'h0000_5000);
        // Protected mode, level 0 then level 3 on task 0
        wr(`PIL_REG_MODE, 32'h01);
        wr(`PIL_REG_FLAGS, 32'h0000_2000);
        rd_chk(`PIL_REG_FLAGS, 32'h0000_2000);
        wr(`PIL_REG_MODE, 32'h07);
        wr(`PIL_REG_FLAGS, 32'h0027_5000);
        rd_chk(`PIL_REG_FLAGS, 32'h0024_6000);
        // Task 1 has its own copy
        wr(`PIL_REG_MODE, 32'h11);
        wr(`PIL_REG_FLAGS, 32'h0000_1000);
        rd_chk(`PIL_REG_FLAGS, 32'h0000_1000);
        wr(`PIL_REG_MODE, 32'h07);
        rd_chk(`PIL_REG_FLAGS, 32'h0024_6000);
        // Level 2 clears nested flag, keeps privilege field
        wr(`PIL_REG_MODE, 32'h05);
        wr(`PIL_REG_FLAGS, 32'h0);
        rd_chk(`PIL_REG_FLAGS, 32'h0000_2000);
        stop_test();
    end

    // Watchdog
    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
